// file: hw/aws_pkg.sv
// Shared constants and types of the area wait-state controller
package aws_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [4:0] AWS_OFF_READ_WAIT = 5'h00;
    localparam logic [4:0] AWS_OFF_DMA_WAIT = 5'h04;
    localparam logic [4:0] AWS_OFF_BUS_AREA = 5'h08;
    localparam logic [4:0] AWS_OFF_LONG_WAIT = 5'h0C;
    localparam logic [4:0] AWS_OFF_STATUS = 5'h10;

    // Values after power-on reset
    localparam logic [15:0] AWS_RST_READ_WAIT = 16'hFFFF;
    localparam logic [15:0] AWS_RST_DMA_WAIT = 16'hFFFF;
    localparam logic [15:0] AWS_RST_BUS_AREA = 16'h0000;
    localparam logic [15:0] AWS_RST_LONG_WAIT = 16'h7800;

    // Read-wait register: reserved bits that always read as one
    localparam logic [15:0] AWS_READ_WAIT_ONES = 16'h00FD;
    localparam int AWS_DRAM_WRITE_PITCH_POS = 1;
    localparam int AWS_AREA_BITS_LSB = 8;
    localparam int AWS_DMA_WRITE_LSB = 0;

    // Bus area control fields
    localparam int AWS_AREA1_DRAM_POS = 0;
    localparam int AWS_AREA6_MUX_IO_POS = 1;
    localparam int AWS_AREA5_PERIPH_POS = 2;
    localparam int AWS_AREA0_ROM_POS = 3;
    localparam int AWS_AREA7_RAM_POS = 4;
    localparam int AWS_REFRESH_WAIT_LSB = 5;
    localparam logic [15:0] AWS_BUS_AREA_MASK = 16'h007F;

    // Long wait fields
    localparam int AWS_LOW_AREA_LW_LSB = 13;
    localparam int AWS_AREA6_LW_LSB = 11;
    localparam logic [15:0] AWS_LONG_WAIT_MASK = 16'h7800;

    // State counts of a bus cycle, one clock per state
    localparam logic [3:0] AWS_ST_ONE = 4'h1;
    localparam logic [3:0] AWS_ST_LONG_PITCH = 4'h2;
    localparam logic [3:0] AWS_ST_PERIPH = 4'h3;
    localparam logic [3:0] AWS_ST_MUX_IO = 4'h4;

    // AXI responses
    localparam logic [1:0] AWS_RESP_OKAY = 2'h0;
    localparam logic [1:0] AWS_RESP_SLVERR = 2'h2;

    // Kind of bus cycle requested by the bus sequencer
    typedef enum logic [2:0] {
        AWS_CPU_READ,
        AWS_CPU_WRITE,
        AWS_DMA_READ,
        AWS_DMA_WRITE,
        AWS_CBR_REFRESH
    } aws_kind_e;

    // One cycle request
    typedef struct packed {
        aws_kind_e kind;
        logic [2:0] area;
    } aws_req_s;

    // Length and sampling decided at the start of a cycle
    typedef struct packed {
        logic [3:0] states;
        logic sample;
    } aws_plan_s;

    // Cycle status shown to the sequencer and to software
    typedef struct packed {
        logic busy;
        logic sampling;
        logic [3:0] last_states;
    } aws_stat_s;

endpackage : aws_pkg

// file: hw/aws_top.sv
// Area wait-state controller: AXI4-Lite registers and bus cycle length engine
//
// Functional notes
// - Read-wait bits 15..8 enable wait sampling per area
// - Areas 1,3,4,5,7 reads: 1 or 2+wait states
// - Areas 0,2,6 reads: 1+long wait, optional wait
// - DRAM column read: short 1, long 2+wait
// - Refresh with area1 bit set: fixed count, no wait
// - Multiplexed I/O reads: always 4+wait states
// - Peripheral space reads: always 3 states, unsampled
// - On-chip ROM/RAM reads: 1 state, unsampled
// - Reserved read-wait bits read one; software writes one
// - DRAM write column: short 1, long 2+wait
// - Area1 external writes with pitch set: 2+wait
// - Wait registers all ones on power-on reset only
// - DMA read bits 15..8 enable wait sampling per area
// - DMA reads areas 1,3,4,5,7: 1 or 2+wait
// - DMA reads areas 0,2,6: 1+long wait, optional wait
// - DMA DRAM column read: short 1, long 2+wait
// - DMA multiplexed I/O reads: always 4+wait states
// - DMA write bits 7..0 mirror DMA read timing
// - Long wait codes 0..3 insert 1..4 states
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps

module aws_top
    import aws_pkg::*;
(
    // Clock and power-on reset
    input wire logic aclk,
    input wire logic aresetn,
    // Manual reset: aborts a cycle, keeps the registers
    input wire logic manual_rst_n,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Bus cycle request from the bus sequencer
    input wire logic cyc_valid,
    input wire aws_req_s cyc_req,
    output logic cyc_ready,
    // Active-low wait input from the external device
    input wire logic wait_n,
    // Cycle progress
    output logic cyc_done,
    output aws_stat_s cyc_stat
);

    // Register contents
    logic [15:0] read_wait_config_reg;
    logic [15:0] dma_wait_config_reg;
    logic [15:0] bus_area_control_reg;
    logic [15:0] long_wait_config_reg;

    // Write channel holding state
    logic aw_have_reg;
    logic w_have_reg;
    logic [4:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // Cycle engine state
    logic [3:0] remain_reg;
    logic sample_reg;
    logic busy_reg;
    logic [3:0] count_reg;
    logic [3:0] last_states_reg;
    logic done_reg;
    logic ready_reg;

    // Decoded strobes of this clock
    logic wr_fire;
    logic cyc_accept;
    logic cyc_last;
    logic cyc_extend;
    aws_plan_s plan;

    // Offset decode shared by both channels
    function automatic logic offset_mapped(input logic [31:0] addr);
        logic hit;
        // Word aligned, upper bits clear
        hit = (addr[31:5] == 27'h0) && (addr[1:0] == 2'h0);
        // Nothing lives past status
        return hit && (addr[4:0] <= AWS_OFF_STATUS);
    endfunction : offset_mapped

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [15:0] res;
        // Lanes 2 and 3 hold nothing
        res = old;
        // Low byte lane
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        // High byte lane
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : lane_merge

    // Long wait code to state count, code 0 inserts one state
    function automatic logic [3:0] long_wait_states(input logic [1:0] code);
        // Code 3, the reset value, gives four
        return {2'h0, code} + AWS_ST_ONE;
    endfunction : long_wait_states

    // Decide length and wait sampling of a new cycle
    function automatic aws_plan_s plan_cycle(input aws_req_s req, input logic [15:0] rwc,
                                             input logic [15:0] dwc, input logic [15:0] bac,
                                             input logic [15:0] lwc);
        aws_plan_s p;
        logic ctl;
        logic [3:0] lw;
        logic [3:0] rfw;
        // Safe default: one state, unsampled
        p.states = AWS_ST_ONE;
        p.sample = 1'b0;
        ctl = 1'b1;
        // Per-area control bit for this kind of cycle
        case (req.kind)
            AWS_CPU_READ: ctl = rwc[AWS_AREA_BITS_LSB + int'(req.area)];
            AWS_CPU_WRITE: begin
                if (req.area == 3'h1) begin
                    ctl = rwc[AWS_DRAM_WRITE_PITCH_POS];
                end else begin
                    ctl = rwc[AWS_AREA_BITS_LSB + int'(req.area)];
                end
            end
            AWS_DMA_READ: ctl = dwc[AWS_AREA_BITS_LSB + int'(req.area)];
            AWS_DMA_WRITE: ctl = dwc[AWS_DMA_WRITE_LSB + int'(req.area)];
            AWS_CBR_REFRESH: ctl = rwc[AWS_AREA_BITS_LSB + 1];
            default: ctl = 1'b1;
        endcase
        // Area 6 has its own code
        if (req.area == 3'h6) begin
            lw = long_wait_states(lwc[AWS_AREA6_LW_LSB +: 2]);
        end else begin
            lw = long_wait_states(lwc[AWS_LOW_AREA_LW_LSB +: 2]);
        end
        // Refresh code, long wait encoding
        rfw = long_wait_states(bac[AWS_REFRESH_WAIT_LSB +: 2]);
        // Space types first, since they override the control bit
        if (req.kind == AWS_CBR_REFRESH) begin
            // Wait line ignored
            p.states = ctl ? (AWS_ST_ONE + rfw) : AWS_ST_ONE;
            p.sample = 1'b0;
        end else if (req.area == 3'h0 && bac[AWS_AREA0_ROM_POS]) begin
            // On-chip ROM never waits
            p.states = AWS_ST_ONE;
            p.sample = 1'b0;
        end else if (req.area == 3'h7 && bac[AWS_AREA7_RAM_POS]) begin
            // On-chip RAM never waits
            p.states = AWS_ST_ONE;
            p.sample = 1'b0;
        end else if (req.area == 3'h5 && bac[AWS_AREA5_PERIPH_POS]) begin
            // Fixed length
            p.states = AWS_ST_PERIPH;
            p.sample = 1'b0;
        end else if (req.area == 3'h6 && bac[AWS_AREA6_MUX_IO_POS]) begin
            // Always sampled, bit ignored
            p.states = AWS_ST_MUX_IO;
            p.sample = 1'b1;
        end else if (req.area == 3'h1 && bac[AWS_AREA1_DRAM_POS]) begin
            // Column pitch from the bit
            p.states = ctl ? AWS_ST_LONG_PITCH : AWS_ST_ONE;
            p.sample = ctl;
        end else if (req.area == 3'h0 || req.area == 3'h2 || req.area == 3'h6) begin
            // Long wait always, sampling by bit
            p.states = AWS_ST_ONE + lw;
            p.sample = ctl;
        end else begin
            // Plain external memory
            p.states = ctl ? AWS_ST_LONG_PITCH : AWS_ST_ONE;
            p.sample = ctl;
        end
        // Wait samples add to it later
        return p;
    endfunction : plan_cycle

    // A pending response blocks a repeat
    assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
    // Taken only while idle
    assign cyc_accept = cyc_valid && ready_reg;
    // Last base state, where wait counts
    assign cyc_last = busy_reg && (remain_reg == AWS_ST_ONE);
    assign cyc_extend = cyc_last && sample_reg && !wait_n;
    // Plan of the request on offer
    assign plan = plan_cycle(cyc_req, read_wait_config_reg, dma_wait_config_reg,
                             bus_area_control_reg, long_wait_config_reg);

    // Write address capture; taken once per write until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            awready <= 1'b1;
        end else if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            // Hole 1F marks a refused write
            aw_addr_reg <= offset_mapped(awaddr) ? awaddr[4:0] : 5'h1F;
            awready <= 1'b0;
        end else if (bvalid && bready) begin
            aw_have_reg <= 1'b0;
            awready <= 1'b1;
        end
    end

    // Write data capture, independent of the address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            wready <= 1'b1;
        end else if (wvalid && wready) begin
            w_have_reg <= 1'b1;
            // May come before the address
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
            wready <= 1'b0;
        end else if (bvalid && bready) begin
            w_have_reg <= 1'b0;
            wready <= 1'b1;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= AWS_RESP_OKAY;
        end else if (wr_fire) begin
            // Set wins over a clear
            bvalid <= 1'b1;
            bresp <= (aw_addr_reg == 5'h1F) ? AWS_RESP_SLVERR : AWS_RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Wait registers; only the power-on reset loads them, manual reset does not
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_wait_config_reg <= AWS_RST_READ_WAIT;
            dma_wait_config_reg <= AWS_RST_DMA_WAIT;
            bus_area_control_reg <= AWS_RST_BUS_AREA;
            long_wait_config_reg <= AWS_RST_LONG_WAIT;
        end else if (wr_fire) begin
            // Reserved ones are forced so a careless write cannot clear them
            // Strobes pick the byte lanes
            case (aw_addr_reg)
                AWS_OFF_READ_WAIT: read_wait_config_reg <= AWS_READ_WAIT_ONES
                    | lane_merge(read_wait_config_reg, w_data_reg, w_strb_reg);
                AWS_OFF_DMA_WAIT: dma_wait_config_reg <=
                    lane_merge(dma_wait_config_reg, w_data_reg, w_strb_reg);
                AWS_OFF_BUS_AREA: bus_area_control_reg <= AWS_BUS_AREA_MASK
                    & lane_merge(bus_area_control_reg, w_data_reg, w_strb_reg);
                AWS_OFF_LONG_WAIT: long_wait_config_reg <= AWS_LONG_WAIT_MASK
                    & lane_merge(long_wait_config_reg, w_data_reg, w_strb_reg);
                // Holes and status take no write
                default: ;
            endcase
        end
    end

    // Read channel: one read at a time, data one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= AWS_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= offset_mapped(araddr) ? AWS_RESP_OKAY : AWS_RESP_SLVERR;
            // Refused reads give zero data
            rdata <= 32'h0000_0000;
            if (offset_mapped(araddr)) begin
                case (araddr[4:0])
                    AWS_OFF_READ_WAIT: rdata <= {16'h0000,
                        read_wait_config_reg | AWS_READ_WAIT_ONES};
                    AWS_OFF_DMA_WAIT: rdata <= {16'h0000, dma_wait_config_reg};
                    AWS_OFF_BUS_AREA: rdata <= {16'h0000, bus_area_control_reg};
                    AWS_OFF_LONG_WAIT: rdata <= {16'h0000, long_wait_config_reg};
                    // Engine as seen at the address edge
                    AWS_OFF_STATUS: rdata <= {26'h0, busy_reg, sample_reg, last_states_reg};
                    default: rdata <= 32'h0000_0000;
                endcase
            end
        end else if (rvalid && rready) begin
            // Next address once data is taken
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Cycle engine: one state per clock, low wait in the last state of a sampled cycle extends it
    always_ff @(posedge aclk) begin
        if (!aresetn || !manual_rst_n) begin
            busy_reg <= 1'b0;
            remain_reg <= 4'h0;
            sample_reg <= 1'b0;
            count_reg <= 4'h0;
        end else if (cyc_accept) begin
            busy_reg <= 1'b1;
            remain_reg <= plan.states;
            // Plan frozen; later writes cannot alter it
            sample_reg <= plan.sample;
            count_reg <= AWS_ST_ONE;
        end else if (busy_reg) begin
            if (cyc_extend) begin
                // Repeat the last state
                count_reg <= count_reg + AWS_ST_ONE;
            end else if (cyc_last) begin
                // Idle until the next take
                busy_reg <= 1'b0;
                sample_reg <= 1'b0;
            end else begin
                remain_reg <= remain_reg - AWS_ST_ONE;
                count_reg <= count_reg + AWS_ST_ONE;
            end
        end
    end

    // Handshake and completion flags toward the sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn || !manual_rst_n) begin
            ready_reg <= 1'b1;
            done_reg <= 1'b0;
            last_states_reg <= 4'h0;
        end else begin
            // Rewritten every clock, so it pulses
            done_reg <= cyc_last && !cyc_extend;
            if (cyc_accept) begin
                ready_reg <= 1'b0;
            end else if (cyc_last && !cyc_extend) begin
                ready_reg <= 1'b1;
                // Kept until the next cycle ends or a manual reset clears it
                last_states_reg <= count_reg;
            end
        end
    end

    // Outputs straight from flip-flops
    assign cyc_ready = ready_reg;
    assign cyc_done = done_reg;
    // Status fields from engine flops
    assign cyc_stat = '{busy: busy_reg, sampling: sample_reg, last_states: last_states_reg};

endmodule : aws_top

// file: verification/aws_top_properties.sv
// Port checks of the area wait-state controller
`timescale 1ns/100ps
module aws_top_properties
    import aws_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic manual_rst_n,
    // Register bus
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic bvalid,
    input wire logic bready,
    // Cycle engine
    input wire logic cyc_valid,
    input wire aws_req_s cyc_req,
    input wire logic cyc_ready,
    input wire logic cyc_done,
    input wire aws_stat_s cyc_stat
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !manual_rst_n);

    // Steps of a bus cycle and of a register read
    sequence s_take;
        cyc_valid && cyc_ready;
    endsequence
    sequence s_refresh;
        s_take ##0 cyc_req.kind == AWS_CBR_REFRESH;
    endsequence
    sequence s_rw_read;
        arvalid && arready && araddr == {27'h0, AWS_OFF_READ_WAIT};
    endsequence

    property p_take_busy; s_take |=> cyc_stat.busy && !cyc_ready; endproperty
    a_take_busy: assert property (p_take_busy) else $error("idle after take");
    property p_end_bound; s_take |-> ##[2:16] cyc_done; endproperty
    a_end_bound: assert property (p_end_bound) else $error("cycle too long");
    property p_done_pulse; cyc_done |=> !cyc_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_fall_done; $fell(cyc_stat.busy) |-> cyc_done && cyc_ready; endproperty
    a_fall_done: assert property (p_fall_done) else $error("end without done");
    // Refresh length comes from the code and the area 1 read bit, so the wait line is never looked at
    property p_refresh_fixed; s_refresh |=> !cyc_stat.sampling; endproperty
    a_refresh_fixed: assert property (p_refresh_fixed) else $error("refresh sampled");
    property p_rw_ones; s_rw_read |=> rdata[7:2] == 6'h3F && rdata[0] && rdata[31:16] == 16'h0;
    endproperty
    a_rw_ones: assert property (p_rw_ones) else $error("reserved bits not one");
    property p_ar_answer; arvalid && arready |=> rvalid && !arready; endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
    property p_r_once; rvalid && rready |=> !rvalid && arready; endproperty
    a_r_once: assert property (p_r_once) else $error("read data repeated");
    property p_b_once; bvalid && bready |=> !bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
endmodule : aws_top_properties

// file: verification/aws_wait_dev.sv
// Behavioural external device that stretches bus cycles with its wait line
`timescale 1ns/100ps
module aws_wait_dev
    import aws_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Cycle progress and how many states the line stays low
    input wire logic busy,
    input wire logic [3:0] low_len,
    // Active-low wait line
    output logic wait_n
);
    logic [3:0] busy_cnt_reg;

    // Count states of the cycle in progress
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) begin
            busy_cnt_reg <= 4'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 4'h1;
        end
    end

    // Low for the first states only; the pull-up holds it high between cycles
    assign wait_n = !(busy && busy_cnt_reg < low_len);
endmodule : aws_wait_dev

// file: verification/tb_top.sv
// Self-checking testbench of the area wait-state controller
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        miscompares++; \
        $display("unexpected at %0t: got %h want %h", $time, got, exp); \
    end \
end
module tb_top
    import aws_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic manual_rst_n = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, cyc_valid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cyc_ready, cyc_done, wait_n;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF, low_len = 4'h0;
    logic [1:0] bresp, rresp;
    aws_req_s cyc_req = '{AWS_CPU_READ, 3'h0};
    aws_stat_s cyc_stat;
    int miscompares = 0, total_checks = 0;

    aws_top i_dut (.*);
    aws_wait_dev i_dev (.aclk(aclk), .aresetn(aresetn), .busy(cyc_stat.busy),
        .low_len(low_len), .wait_n(wait_n));

    // Clock, 8 ns period
    initial begin
        forever #4 aclk = ~aclk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Register write; address and data channels are released independently
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
        logic ta, tw, fin;
        fin = 1'b0;
        @(posedge aclk);
        awaddr <= {27'h0, a};
        wdata <= {16'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 64 && !fin; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            fin = bvalid && bready;
            if (fin) `CHK(bresp, er)
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (fin) bready <= 1'b0;
        end
        `CHK(fin, 1'b1)
    endtask : wr

    // Register read compared with the expected word and response
    task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
        logic ta, fin;
        fin = 1'b0;
        @(posedge aclk);
        araddr <= {27'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 64 && !fin; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            fin = rvalid && rready;
            if (fin) `CHK({rdata, rresp}, {ed, er})
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (fin) rready <= 1'b0;
        end
        `CHK(fin, 1'b1)
    endtask : rd

    // One bus cycle; lo states of low wait, ex total states expected
    task automatic cyc(input aws_kind_e k, input logic [2:0] ar, input logic [3:0] lo,
            input logic [3:0] ex);
        logic t, fin;
        t = 1'b0;
        fin = 1'b0;
        @(posedge aclk);
        cyc_req <= '{k, ar};
        cyc_valid <= 1'b1;
        low_len <= lo;
        for (int n = 0; n < 64 && !t; n++) begin
            @(negedge aclk);
            t = cyc_ready;
            @(posedge aclk);
            if (t) cyc_valid <= 1'b0;
        end
        for (int n = 0; n < 64 && !fin; n++) begin
            @(negedge aclk);
            fin = cyc_done;
        end
        `CHK(fin, 1'b1)
        `CHK(cyc_stat.last_states, ex)
    endtask : cyc

    task automatic t_reset_values();
        rd(AWS_OFF_READ_WAIT, 32'hFFFF);
        rd(AWS_OFF_DMA_WAIT, 32'hFFFF);
        rd(AWS_OFF_LONG_WAIT, 32'h7800);
        rd(5'h14, 32'h0, AWS_RESP_SLVERR);
        wr(5'h16, 16'h0, AWS_RESP_SLVERR);
        wr(AWS_OFF_READ_WAIT, 16'h0002);
        rd(AWS_OFF_READ_WAIT, 32'h00FF);
        $display("test reset done");
    endtask : t_reset_values

    // External areas, per-area bits and every long wait code
    task automatic t_cpu_reads();
        cyc(AWS_CPU_READ, 3'h3, 4'h4, 4'h1);
        cyc(AWS_CPU_READ, 3'h0, 4'h0, 4'h5);
        cyc(AWS_CPU_WRITE, 3'h1, 4'h2, 4'h3);
        wr(AWS_OFF_READ_WAIT, 16'h08FF);
        cyc(AWS_CPU_READ, 3'h3, 4'h3, 4'h4);
        cyc(AWS_CPU_READ, 3'h4, 4'h3, 4'h1);
        wr(AWS_OFF_READ_WAIT, 16'hFFFF);
        cyc(AWS_CPU_READ, 3'h6, 4'h5, 4'h6);
        for (int c = 0; c < 4; c++) begin
            wr(AWS_OFF_LONG_WAIT, 16'(c) * 16'h2800);
            cyc(AWS_CPU_READ, 3'h2, 4'h0, 4'(c + 2));
            cyc(AWS_CPU_READ, 3'h6, 4'h0, 4'(c + 2));
        end
        $display("test cpu reads done");
    endtask : t_cpu_reads

    // Fixed spaces ignore the read bits, tried with bits clear and set
    task automatic t_special();
        wr(AWS_OFF_BUS_AREA, 16'h001E);
        for (int i = 0; i < 2; i++) begin
            wr(AWS_OFF_READ_WAIT, i ? 16'hFFFF : 16'h00FF);
            cyc(AWS_CPU_READ, 3'h6, 4'h4, 4'h5);
            cyc(AWS_CPU_READ, 3'h5, 4'h6, 4'h3);
            cyc(AWS_CPU_READ, 3'h0, 4'h3, 4'h1);
            cyc(AWS_CPU_READ, 3'h7, 4'h3, 4'h1);
        end
        wr(AWS_OFF_BUS_AREA, 16'h0000);
        $display("test fixed spaces done");
    endtask : t_special

    // Area 1 as DRAM with refresh code 2; pitch is set again before leaving
    task automatic t_dram();
        wr(AWS_OFF_BUS_AREA, 16'h0041);
        rd(AWS_OFF_BUS_AREA, 32'h0041);
        wr(AWS_OFF_READ_WAIT, 16'h00FD);
        cyc(AWS_CPU_READ, 3'h1, 4'h3, 4'h1);
        cyc(AWS_CPU_WRITE, 3'h1, 4'h3, 4'h1);
        wr(AWS_OFF_READ_WAIT, 16'hFFFF);
        cyc(AWS_CPU_READ, 3'h1, 4'h2, 4'h3);
        cyc(AWS_CPU_WRITE, 3'h1, 4'h2, 4'h3);
        cyc(AWS_CBR_REFRESH, 3'h1, 4'h6, 4'h4);
        wr(AWS_OFF_BUS_AREA, 16'h0000);
        $display("test dram done");
    endtask : t_dram

    task automatic t_dma();
        wr(AWS_OFF_DMA_WAIT, 16'h0000);
        cyc(AWS_DMA_READ, 3'h4, 4'h3, 4'h1);
        cyc(AWS_DMA_WRITE, 3'h2, 4'h3, 4'h5);
        wr(AWS_OFF_DMA_WAIT, 16'hFF00);
        cyc(AWS_DMA_READ, 3'h3, 4'h2, 4'h3);
        cyc(AWS_DMA_WRITE, 3'h3, 4'h3, 4'h1);
        cyc(AWS_DMA_READ, 3'h0, 4'h5, 4'h6);
        wr(AWS_OFF_BUS_AREA, 16'h0003);
        cyc(AWS_DMA_READ, 3'h1, 4'h2, 4'h3);
        wr(AWS_OFF_DMA_WAIT, 16'h0000);
        cyc(AWS_DMA_READ, 3'h1, 4'h3, 4'h1);
        cyc(AWS_DMA_READ, 3'h6, 4'h4, 4'h5);
        wr(AWS_OFF_BUS_AREA, 16'h0000);
        $display("test dma done");
    endtask : t_dma

    // Manual reset must leave the registers alone
    task automatic t_manual();
        wr(AWS_OFF_DMA_WAIT, 16'h1234);
        @(posedge aclk);
        manual_rst_n <= 1'b0;
        repeat (2) @(posedge aclk);
        manual_rst_n <= 1'b1;
        rd(AWS_OFF_DMA_WAIT, 32'h1234);
        rd(AWS_OFF_READ_WAIT, 32'hFFFF);
        cyc(AWS_CPU_READ, 3'h3, 4'h0, 4'h2);
        rd(AWS_OFF_STATUS, 32'h0002);
        $display("test manual reset done");
    endtask : t_manual

    // Main sequence after 16 cycles of power-on reset
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_values();
        t_cpu_reads();
        t_special();
        t_dram();
        t_dma();
        t_manual();
        give_verdict();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule : tb_top

bind aws_top aws_top_properties i_props (.aclk(aclk), .aresetn(aresetn),
    .manual_rst_n(manual_rst_n), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .bvalid(bvalid), .bready(bready),
    .cyc_valid(cyc_valid), .cyc_req(cyc_req), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
    .cyc_stat(cyc_stat));
